//--- backplane_model.sv
// backplane and interrupt controller model facing the front panel block
module backplane_model (
   // clock
   input  wire logic       i_mclk,
   // backplane
   input  wire logic       i_sysreset_oe_n,
   input  wire logic       i_sysreset_out,
   output logic            o_sysreset_n,
   input  wire logic       i_bp_start,
   input  wire logic       i_bp_busy,
   input  wire logic [7:0] i_done_dly,
   output logic            o_bp_done,
   // serial interrupt frame
   input  wire logic       i_serint_sync,
   input  wire logic       i_serint_data,
   output logic [3:0]      o_slot
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_ff;
   logic [3:0] pos_ff;
   // wired line with pull-up
   assign o_sysreset_n = i_sysreset_oe_n ? 1'b1 : i_sysreset_out;
   // slave answers after i_done_dly cycles, zero never answers
   always_ff @(posedge i_mclk) begin
      o_bp_done <= 1'b0;
      if (i_bp_start) cnt_ff <= 8'h00;
      else if (i_bp_busy) cnt_ff <= cnt_ff + 8'h01;
      if (i_bp_busy && i_done_dly != 8'h00 && cnt_ff == i_done_dly) o_bp_done <= 1'b1;
   end
   // slot of the interrupt bit within the frame
   always_ff @(posedge i_mclk) begin
      pos_ff <= i_serint_sync ? 4'h1 : pos_ff + 4'h1;
      if (i_serint_data) o_slot <= pos_ff;
   end
endmodule

//--- front_panel_reset_control.sv
// front panel abort/reset buttons, status lamps and backplane system reset
module front_panel_reset_control
   import front_panel_reset_control_pkg::*;
#(
   parameter int P_SYSRST_HOLD_CYC = SYSRST_HOLD_CYC,
   parameter int P_DEBOUNCE_CYC    = DEBOUNCE_CYC,
   parameter int P_BUS_TIMEOUT_CYC = BUS_TIMEOUT_CYC
) (
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_sys_rst,
   // avalon-mm slave
   input  wire logic [7:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   // front panel pins
   input  wire logic        i_abort_button_n,
   input  wire logic        i_reset_button_n,
   input  wire logic        i_syscon_sel,
   input  wire logic        i_watchdog_timeout,
   input  wire logic        i_rom_busy,
   input  wire logic        i_sdram_busy,
   input  wire logic        i_pci_busy,
   output logic             o_board_fail_lamp,
   output logic             o_controller_lamp,
   output logic             o_activity_lamp,
   // resets
   output logic             o_board_reset,
   output logic             o_processor_hard_reset_n,
   input  wire logic        i_sysreset_n,
   output logic             o_sysreset_out,
   output logic             o_sysreset_oe_n,
   // interrupts
   output logic             o_irq,
   output logic             o_serint_sync,
   output logic             o_serint_data,
   output logic [3:0]       o_abort_level,
   // backplane cycle, same clock bridge logic
   input  wire logic        i_bp_start,
   input  wire logic [31:0] i_bp_addr,
   input  wire logic        i_bp_done,
   input  wire logic        i_global_timeout,
   input  wire logic [3:0]  i_bp_loc_mon_set,
   output logic             o_bp_busy,
   output logic             o_bp_error,
   output logic [1:0]       o_bp_space,
   output logic             o_p2_addr_hi_en,
   output logic             o_p2_data_hi_en,
   output logic [3:0]       o_loc_mon
);
   default clocking cb_mclk @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   if (P_SYSRST_HOLD_CYC < 2 || P_DEBOUNCE_CYC < 2 || P_BUS_TIMEOUT_CYC < 2) begin : g_bad_count
      $error("front_panel_reset_control: counts must be at least 2");
   end
   localparam int HOLD_W = $clog2(P_SYSRST_HOLD_CYC + 1);
   localparam int DEB_W  = $clog2(P_DEBOUNCE_CYC + 1);
   localparam int BTO_W  = $clog2(P_BUS_TIMEOUT_CYC + 1);
   localparam int PIN_N  = 8;
   localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(P_SYSRST_HOLD_CYC - 1);
   localparam logic [DEB_W-1:0]  DEB_LAST  = DEB_W'(P_DEBOUNCE_CYC - 1);
   localparam logic [BTO_W-1:0]  BTO_LAST  = BTO_W'(P_BUS_TIMEOUT_CYC - 1);

   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction
   function automatic logic [1:0] space_of(input logic [31:0] addr);
      if (addr >= A16_BASE) begin
         space_of = SPACE_A16;
      end else if (addr >= A24_BASE) begin
         space_of = SPACE_A24;
      end else begin
         space_of = SPACE_A32;
      end
   endfunction

   //-------------------------------------------------------------------------
   // pin synchronisers
   //-------------------------------------------------------------------------
   logic [PIN_N-1:0] pin_raw;
   logic [PIN_N-1:0] pin_meta_ff;
   logic [PIN_N-1:0] pin_sync_ff;
   assign pin_raw = {i_sysreset_n, i_pci_busy, i_sdram_busy, i_rom_busy,
                     i_watchdog_timeout, i_syscon_sel, i_reset_button_n, i_abort_button_n};

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pin_meta_ff <= 8'h03;
         pin_sync_ff <= 8'h03;
      end else begin
         pin_meta_ff <= pin_raw;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   logic syscon;
   logic any_busy;
   logic wdog_sync;
   logic sysrst_line_n;
   assign syscon        = pin_sync_ff[2];
   assign wdog_sync     = pin_sync_ff[3];
   assign any_busy      = |pin_sync_ff[6:4];
   assign sysrst_line_n = pin_sync_ff[7];

   //-------------------------------------------------------------------------
   // button debouncers: 0 abort, 1 reset; level is pressed-high
   //-------------------------------------------------------------------------
   logic [1:0] deb_ff;
   logic [1:0] deb_prev_ff;
   genvar gb;
   generate
      for (gb = 0; gb < 2; gb++) begin : g_deb
         logic [DEB_W-1:0] cnt_ff;
         always_ff @(posedge i_mclk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
               cnt_ff     <= '0;
               deb_ff[gb] <= 1'b0;
            end else if (!pin_sync_ff[gb] == deb_ff[gb]) begin
               cnt_ff <= '0;
            end else if (cnt_ff == DEB_LAST) begin
               cnt_ff     <= '0;
               deb_ff[gb] <= !pin_sync_ff[gb];
            end else begin
               cnt_ff <= cnt_ff + 1'b1;
            end
         end
      end
   endgenerate

   logic wdog_prev_ff;
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         deb_prev_ff  <= 2'h0;
         wdog_prev_ff <= 1'b0;
      end else begin
         deb_prev_ff  <= deb_ff;
         wdog_prev_ff <= wdog_sync;
      end
   end

   logic abort_press;
   logic reset_pressed;
   logic wdog_event;
   assign abort_press   = deb_ff[0] && !deb_prev_ff[0];
   assign reset_pressed = deb_ff[1];
   assign wdog_event    = wdog_sync && !wdog_prev_ff;

   //-------------------------------------------------------------------------
   // register bus
   //-------------------------------------------------------------------------
   logic        ack_ff;
   logic        req;
   logic        wr_take;
   logic [31:0] wdata;
   logic [7:0]  ctrl_ff;
   logic [7:0]  sys_stat2_ff;
   logic        misc_sysrst_ff;
   logic [3:0]  loc_mon_ff;
   logic [2:0]  irq_status_ff;
   logic [2:0]  irq_mask_ff;
   logic [31:0] avs_readdata_ff;
   logic        sysrst_active_ff;

   assign req               = i_avs_read || i_avs_write;
   assign o_avs_waitrequest = req && !ack_ff;
   assign wr_take           = i_avs_write && ack_ff;
   assign wdata             = i_avs_writedata & lane_mask(i_avs_byteenable);

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req && !ack_ff;
      end
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         avs_readdata_ff <= 32'h0000_0000;
      end else if (i_avs_read && !ack_ff) begin
         unique case (i_avs_address)
            OFS_CTRL:       avs_readdata_ff <= {24'h00_0000, ctrl_ff};
            OFS_STATUS:     avs_readdata_ff <= {28'h000_0000, !sysrst_line_n, sysrst_active_ff,
                                                syscon, deb_ff[0]};
            OFS_SYS_STAT2:  avs_readdata_ff <= {24'h00_0000, sys_stat2_ff};
            OFS_MISC_CTRL:  avs_readdata_ff <= {31'h0000_0000, misc_sysrst_ff};
            OFS_LOC_MON:    avs_readdata_ff <= {28'h000_0000, loc_mon_ff};
            OFS_IRQ_STATUS: avs_readdata_ff <= {29'h0000_0000, irq_status_ff};
            OFS_IRQ_MASK:   avs_readdata_ff <= {29'h0000_0000, irq_mask_ff};
            default:        avs_readdata_ff <= 32'h0000_0000;
         endcase
      end
   end
   assign o_avs_readdata = avs_readdata_ff;

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl_ff      <= CTRL_RST;
         sys_stat2_ff <= SYS_STAT2_RST;
         irq_mask_ff  <= IRQ_MASK_RST;
      end else if (wr_take) begin
         if (i_avs_address == OFS_CTRL && i_avs_byteenable[0]) begin
            ctrl_ff <= wdata[7:0];
         end
         if (i_avs_address == OFS_SYS_STAT2 && i_avs_byteenable[0]) begin
            sys_stat2_ff <= {7'h00, wdata[BOARD_FAIL_BIT]};
         end
         if (i_avs_address == OFS_IRQ_MASK && i_avs_byteenable[0]) begin
            irq_mask_ff <= wdata[IRQ_W-1:0];
         end
      end
   end

   // miscellaneous control: writing the bit requests one system reset
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         misc_sysrst_ff <= 1'b0;
      end else begin
         misc_sysrst_ff <= wr_take && i_avs_address == OFS_MISC_CTRL && wdata[MISC_SYSRST_BIT];
      end
   end

   // location monitors: local write or backplane set, set wins
   logic [3:0] loc_mon_base;
   assign loc_mon_base = (wr_take && i_avs_address == OFS_LOC_MON) ? wdata[LOC_MON_W-1:0] : loc_mon_ff;
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         loc_mon_ff <= 4'h0;
      end else begin
         loc_mon_ff <= loc_mon_base | i_bp_loc_mon_set;
      end
   end
   assign o_loc_mon = loc_mon_ff;
   //-------------------------------------------------------------------------
   // interrupt status, mask and serial frame
   //-------------------------------------------------------------------------
   logic [2:0] irq_set;
   logic [2:0] irq_clr;
   assign irq_set = {|i_bp_loc_mon_set, wdog_event, abort_press && ctrl_ff[CTRL_ABORT_EN]};
   assign irq_clr = (wr_take && i_avs_address == OFS_IRQ_STATUS) ? wdata[IRQ_W-1:0] : 3'h0;

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         irq_status_ff <= 3'h0;
      end else begin
         irq_status_ff <= (irq_status_ff & ~irq_clr) | irq_set;
      end
   end
   assign o_irq = |(irq_status_ff & irq_mask_ff);
   logic [3:0] slot_ff;
   logic       ser_sync_ff;
   logic       ser_data_ff;
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         slot_ff     <= 4'h0;
         ser_sync_ff <= 1'b0;
         ser_data_ff <= 1'b0;
      end else begin
         slot_ff     <= 4'(slot_ff + 1'b1);
         ser_sync_ff <= slot_ff == 4'h0;
         ser_data_ff <= slot_ff == ABORT_SER_SLOT && irq_status_ff[IRQ_ABORT]
                        && irq_mask_ff[IRQ_ABORT];
      end
   end
   assign o_serint_sync = ser_sync_ff;
   assign o_serint_data = ser_data_ff;
   assign o_abort_level = ctrl_ff[CTRL_LEVEL_LSB +: LEVEL_W];

   //-------------------------------------------------------------------------
   // board reset and backplane system reset
   //-------------------------------------------------------------------------
   logic              por_ff;
   logic [HOLD_W-1:0] hold_cnt_ff;
   logic              sysrst_req;
   logic              board_reset_ff;
   logic              sysrst_oe_n_ff;
   assign sysrst_req = reset_pressed || por_ff || wdog_sync || misc_sysrst_ff;

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         por_ff           <= 1'b1;
         hold_cnt_ff      <= HOLD_LOAD;
         sysrst_active_ff <= 1'b1;
      end else begin
         por_ff <= 1'b0;
         if (sysrst_req) begin
            hold_cnt_ff      <= HOLD_LOAD;
            sysrst_active_ff <= 1'b1;
         end else if (hold_cnt_ff != '0) begin
            hold_cnt_ff <= hold_cnt_ff - 1'b1;
         end else begin
            sysrst_active_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         board_reset_ff <= 1'b1;
         sysrst_oe_n_ff <= 1'b1;
      end else begin
         board_reset_ff <= reset_pressed;
         sysrst_oe_n_ff <= !(sysrst_active_ff && syscon);
      end
   end
   assign o_board_reset            = board_reset_ff;
   assign o_processor_hard_reset_n = !board_reset_ff;
   assign o_sysreset_out           = 1'b0;
   assign o_sysreset_oe_n          = sysrst_oe_n_ff;

   //-------------------------------------------------------------------------
   // lamps
   //-------------------------------------------------------------------------
   logic ctrl_lamp_ff;
   logic act_lamp_ff;
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl_lamp_ff <= 1'b0;
         act_lamp_ff  <= 1'b0;
      end else begin
         ctrl_lamp_ff <= syscon;
         act_lamp_ff  <= any_busy;
      end
   end
   assign o_board_fail_lamp = board_reset_ff || sys_stat2_ff[BOARD_FAIL_BIT];
   assign o_controller_lamp = ctrl_lamp_ff;
   assign o_activity_lamp   = act_lamp_ff;

   //-------------------------------------------------------------------------
   // backplane cycle watch and address space
   //-------------------------------------------------------------------------
   logic             bp_busy_ff;
   logic             bp_error_ff;
   logic [BTO_W-1:0] bto_cnt_ff;
   logic [1:0]       bp_space_ff;
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         bp_busy_ff  <= 1'b0;
         bp_error_ff <= 1'b0;
         bto_cnt_ff  <= '0;
         bp_space_ff <= SPACE_A32;
      end else begin
         bp_error_ff <= 1'b0;
         if (!bp_busy_ff) begin
            bto_cnt_ff <= '0;
            if (i_bp_start) begin
               bp_busy_ff  <= 1'b1;
               bp_space_ff <= space_of(i_bp_addr);
            end
         end else if (i_bp_done) begin
            bp_busy_ff <= 1'b0;
         end else if (i_global_timeout || (syscon && bto_cnt_ff == BTO_LAST)) begin
            bp_busy_ff  <= 1'b0;
            bp_error_ff <= 1'b1;
         end else if (syscon) begin
            bto_cnt_ff <= bto_cnt_ff + 1'b1;
         end
         // otherwise keep waiting with no limit
      end
   end
   assign o_bp_busy       = bp_busy_ff;
   assign o_bp_error      = bp_error_ff;
   assign o_bp_space      = bp_space_ff;
   assign o_p2_addr_hi_en = bp_busy_ff && bp_space_ff == SPACE_A32;
   assign o_p2_data_hi_en = bp_busy_ff;
   //-------------------------------------------------------------------------
   // assertions
   //-------------------------------------------------------------------------
   a_abort_edge_sets: assert property (abort_press && ctrl_ff[CTRL_ABORT_EN] |=> irq_status_ff[IRQ_ABORT])
      else $error("abort press did not set status");
   a_abort_disabled: assert property (
      $rose(irq_status_ff[IRQ_ABORT]) |-> $past(abort_press && ctrl_ff[CTRL_ABORT_EN]))
      else $error("abort status set without enabled press");
   a_abort_pending: assert property (
      (irq_status_ff[IRQ_ABORT] && !irq_clr[IRQ_ABORT]) |=> irq_status_ff[IRQ_ABORT])
      else $error("abort request lost before clear");
   a_serial_slot: assert property (o_serint_data |-> $past(slot_ff) == ABORT_SER_SLOT)
      else $error("abort sent outside slot 14");
   a_sysrst_hold: assert property (
      $fell(sysrst_active_ff) |-> ($past(hold_cnt_ff) == '0 && !$past(sysrst_req)))
      else $error("system reset released early");
   a_sysrst_syscon: assert property (!syscon ##1 !syscon |-> o_sysreset_oe_n)
      else $error("system reset driven while not controller");
   a_button_reset: assert property (reset_pressed |=> (o_board_reset && !o_processor_hard_reset_n
      && o_board_fail_lamp) ##1 (!o_sysreset_oe_n == $past(syscon)))
      else $error("reset button did not reset board");
   a_ctrl_lamp: assert property (##1 o_controller_lamp == $past(syscon))
      else $error("controller lamp mismatch");
   a_activity_lamp: assert property (any_busy |=> o_activity_lamp)
      else $error("activity lamp dark during access");
   a_wait_forever: assert property (
      (bp_busy_ff && !syscon && !i_global_timeout && !i_bp_done) |=> (bp_busy_ff && !bp_error_ff))
      else $error("non controller abandoned backplane cycle");
   a_avs_one_wait: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("bus answer not after one wait state");
endmodule

//--- front_panel_reset_control_pkg.sv
// constants, register map and timing for the front panel reset control block
//----------------------------------------------------------------------------
// Overview of operation
//----------------------------------------------------------------------------
// Overview of operation
// - enabled abort press requests a processor interrupt at a software set level.
// - abort interrupt travels on serial interrupt source slot 14.
// - abort button level is readable as a general purpose input bit.
// - abort interrupt is edge triggered and debounced, one event per press.
// - reset button resets all board devices and asserts processor hard reset.
// - reset button also drives backplane system reset when system controller.
// - board fail lamp is lit while the board is in hard reset.
// - software turns board fail lamp on or off through bit 0 of status two.
// - controller lamp is lit exactly while the board is system controller.
// - activity lamp lights during boot flash, sdram or pci accesses.
// - as system controller the reset driver asserts backplane system reset.
// - system reset sources: button, power up, watchdog, miscellaneous control bit.
// - backplane system reset stays asserted at least 200 ms once raised.
// - non controller without global timeout waits unlimited for a backplane cycle.
// - master and slave use 32 bit address and data, serving A16 and A24 windows.
// - second connector carries upper 16 data bits and upper 8 address lines.
// - one register holds four location monitor bits, reachable locally and remotely.
package front_panel_reset_control_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_STATUS     = 8'h04;
   localparam logic [7:0] OFS_SYS_STAT2  = 8'h08;
   localparam logic [7:0] OFS_MISC_CTRL  = 8'h0C;
   localparam logic [7:0] OFS_LOC_MON    = 8'h10;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;
   // field positions
   localparam int CTRL_ABORT_EN   = 0;
   localparam int CTRL_LEVEL_LSB  = 4;
   localparam int LEVEL_W         = 4;
   localparam int BOARD_FAIL_BIT  = 0;
   localparam int MISC_SYSRST_BIT = 0;
   localparam int IRQ_ABORT       = 0;
   localparam int IRQ_WATCHDOG    = 1;
   localparam int IRQ_LOC_MON     = 2;
   localparam int IRQ_W           = 3;
   localparam int LOC_MON_W       = 4;
   // values after reset
   localparam logic [7:0] CTRL_RST     = 8'h00;
   localparam logic [7:0] SYS_STAT2_RST = 8'h00;
   localparam logic [2:0] IRQ_MASK_RST  = 3'h0;
   // serial interrupt frame
   localparam int          SER_SLOTS      = 16;
   localparam logic [3:0]  ABORT_SER_SLOT = 4'hE;
   // backplane address spaces
   localparam logic [1:0]  SPACE_A32   = 2'h0;
   localparam logic [1:0]  SPACE_A24   = 2'h1;
   localparam logic [1:0]  SPACE_A16   = 2'h2;
   localparam logic [31:0] A16_BASE    = 32'hFFFF_0000;
   localparam logic [31:0] A24_BASE    = 32'hFF00_0000;
   // timing
   localparam int CLK_HZ          = 200_000_000;
   localparam int SYSRST_HOLD_MS  = 200;
   localparam int DEBOUNCE_MS     = 10;
   localparam int BUS_TIMEOUT_US  = 100;
   localparam int SYSRST_HOLD_CYC = SYSRST_HOLD_MS * (CLK_HZ / 1000);
   localparam int DEBOUNCE_CYC    = DEBOUNCE_MS * (CLK_HZ / 1000);
   localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_US * (CLK_HZ / 1_000_000);
endpackage

//--- front_panel_reset_control_tb.sv
// self-checking bench for the front panel reset control block
module front_panel_reset_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import front_panel_reset_control_pkg::*;
   logic        i_mclk = 1'b0, i_sys_rst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
   logic [7:0]  i_avs_address = 8'h00, dly = 8'h00;
   logic [31:0] i_avs_writedata = 32'h0000_0000, i_bp_addr = 32'h0000_0000, o_avs_readdata, q;
   logic [3:0]  i_avs_byteenable = 4'hF, i_bp_loc_mon_set = 4'h0, o_abort_level, o_loc_mon, slot;
   logic        i_abort_button_n = 1'b1, i_reset_button_n = 1'b1, i_syscon_sel = 1'b1;
   logic        i_watchdog_timeout = 1'b0, i_bp_start = 1'b0, i_global_timeout = 1'b0;
   logic [2:0]  bsy = 3'h0;
   logic        i_bp_done, i_sysreset_n, o_avs_waitrequest, o_board_fail_lamp, o_controller_lamp;
   logic        o_activity_lamp, o_board_reset, o_processor_hard_reset_n, o_sysreset_out, o_sysreset_oe_n;
   logic        o_irq, o_serint_sync, o_serint_data, o_bp_busy, o_bp_error, o_p2_addr_hi_en, o_p2_data_hi_en;
   logic [1:0]  o_bp_space;
   logic [31:0] adr [3] = '{32'h1000_0000, 32'hFF12_3456, 32'hFFFF_1234};
   logic [4:0]  exp [3] = '{5'h1C, 5'h19, 5'h1A};
   int          fails = 0, checks = 0, n;

   front_panel_reset_control #(.P_SYSRST_HOLD_CYC(50), .P_DEBOUNCE_CYC(8), .P_BUS_TIMEOUT_CYC(20))
   u_front_panel_reset_control (.i_mclk, .i_sys_rst, .i_avs_address, .i_avs_read, .i_avs_write,
      .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_abort_button_n,
      .i_reset_button_n, .i_syscon_sel, .i_watchdog_timeout, .i_rom_busy(bsy[0]), .i_sdram_busy(bsy[1]),
      .i_pci_busy(bsy[2]), .o_board_fail_lamp, .o_controller_lamp, .o_activity_lamp, .o_board_reset,
      .o_processor_hard_reset_n, .i_sysreset_n, .o_sysreset_out, .o_sysreset_oe_n, .o_irq, .o_serint_sync,
      .o_serint_data, .o_abort_level, .i_bp_start, .i_bp_addr, .i_bp_done, .i_global_timeout,
      .i_bp_loc_mon_set, .o_bp_busy, .o_bp_error, .o_bp_space, .o_p2_addr_hi_en, .o_p2_data_hi_en, .o_loc_mon);
   backplane_model u_backplane_model (.i_mclk, .i_sysreset_oe_n(o_sysreset_oe_n),
      .i_sysreset_out(o_sysreset_out), .o_sysreset_n(i_sysreset_n), .i_bp_start, .i_bp_busy(o_bp_busy),
      .i_done_dly(dly), .o_bp_done(i_bp_done), .i_serint_sync(o_serint_sync), .i_serint_data(o_serint_data),
      .o_slot(slot));

   always #2.5 i_mclk = ~i_mclk;
   //----------------------------------------------------------------------
   // tasks
   //----------------------------------------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge i_mclk);
   endtask
   // one avalon access, held until waitrequest is sampled low
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_write <= w;
      i_avs_read <= !w;
      do begin
         @(posedge i_mclk);
      end while (o_avs_waitrequest !== 1'b0);
      q = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
   endtask
   task automatic press(input int c);
      i_abort_button_n <= 1'b0;
      cyc(c);
      i_abort_button_n <= 1'b1;
   endtask
   task automatic results();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #100us;
      fails++;
      results();
   end
   //----------------------------------------------------------------------
   // tests
   //----------------------------------------------------------------------
   initial begin
      cyc(2);
      chk(o_board_fail_lamp, 1);
      chk(o_processor_hard_reset_n, 0);
      cyc(1);
      i_sys_rst <= 1'b0;
      cyc(10);
      chk(i_sysreset_n, 0);
      chk(o_controller_lamp, 1);
      cyc(60);
      acc(1, OFS_MISC_CTRL, 32'h0000_0001);
      cyc(3);
      chk(o_sysreset_oe_n, 0);
      n = 0;
      while (o_sysreset_oe_n !== 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      chk(n >= 47 && n <= 60, 1);
      i_watchdog_timeout <= 1'b1;
      cyc(6);
      chk(o_sysreset_oe_n, 0);
      i_watchdog_timeout <= 1'b0;
      i_syscon_sel <= 1'b0;
      cyc(70);
      chk(o_controller_lamp, 0);
      i_reset_button_n <= 1'b0;
      cyc(20);
      chk({o_board_reset, o_processor_hard_reset_n, o_board_fail_lamp, o_sysreset_oe_n}, 4'hB);
      i_reset_button_n <= 1'b1;
      cyc(70);
      acc(1, OFS_SYS_STAT2, 32'h0000_0001);
      acc(0, OFS_SYS_STAT2, 32'h0000_0000);
      chk({q[30:0], o_board_fail_lamp}, 32'h0000_0003);
      acc(1, OFS_SYS_STAT2, 32'h0000_0000);
      cyc(1);
      chk(o_board_fail_lamp, 0);
      for (int i = 0; i < 3; i++) begin
         bsy <= 3'h1 << i;
         cyc(5);
         chk(o_activity_lamp, 1);
         bsy <= 3'h0;
         cyc(5);
         chk(o_activity_lamp, 0);
      end
      acc(1, OFS_IRQ_STATUS, 32'h0000_0007);
      acc(1, OFS_IRQ_MASK, 32'h0000_0007);
      acc(1, OFS_CTRL, 32'h0000_0051);
      for (int i = 0; i < 6; i++) begin
         i_abort_button_n <= i[0];
         cyc(3);
      end
      cyc(10);
      chk({o_irq, o_abort_level}, 5'h05);
      press(16);
      acc(0, OFS_STATUS, 32'h0000_0000);
      chk({o_irq, q[0]}, 2'h3);
      cyc(20);
      chk(slot, ABORT_SER_SLOT);
      acc(0, OFS_IRQ_STATUS, 32'h0000_0000);
      chk(q, 1);
      acc(1, OFS_IRQ_STATUS, 32'h0000_0001);
      cyc(1);
      chk(o_irq, 0);
      acc(1, OFS_CTRL, 32'h0000_0000);
      press(16);
      cyc(16);
      acc(0, OFS_IRQ_STATUS, 32'h0000_0000);
      chk(q, 0);
      acc(1, OFS_IRQ_MASK, 32'h0000_0000);
      i_bp_loc_mon_set <= 4'h5;
      cyc(1);
      i_bp_loc_mon_set <= 4'h0;
      cyc(3);
      chk({o_loc_mon, o_irq}, 5'h0A);
      acc(1, OFS_IRQ_MASK, 32'h0000_0004);
      cyc(1);
      chk(o_irq, 1);
      acc(1, OFS_IRQ_STATUS, 32'h0000_0004);
      acc(1, OFS_LOC_MON, 32'h0000_000A);
      acc(0, OFS_LOC_MON, 32'h0000_0000);
      chk({q[30:0], o_irq}, 32'h0000_0014);
      acc(0, 8'h1C, 32'h0000_0000);
      chk(q, 0);
      dly <= 8'h03;
      for (int i = 0; i < 4; i++) begin
         if (i == 3) dly <= 8'h00;
         i_bp_addr <= adr[i % 3];
         i_bp_start <= 1'b1;
         cyc(1);
         i_bp_start <= 1'b0;
         cyc(2);
         chk({o_bp_busy, o_p2_data_hi_en, o_p2_addr_hi_en, o_bp_space}, exp[i % 3]);
         cyc(40);
         chk(o_bp_busy, i == 3);
      end
      i_global_timeout <= 1'b1;
      cyc(2);
      chk(o_bp_error, 1);
      i_global_timeout <= 1'b0;
      cyc(1);
      chk(o_bp_busy, 0);
      results();
   end
endmodule
